/* File: logic/lge_pkg.sv */
// Constants and register map of the light grid output evaluator
package lge_pkg;
   localparam int BEAMS = 32;
   localparam int CW = 6;
   localparam int NOUT = 2;
   localparam int NZONE = 4;
   localparam int AW = 8;
   localparam int CLK_HZ = 10_000_000;
   localparam int MIN_UNIT_MS = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * MIN_UNIT_MS;
   localparam int SUBW = 14;
   localparam int MSW = 16;
   // Register byte addresses
   localparam logic [7:0] ZONE_BASE = 8'h00;
   localparam logic [7:0] OUT_BASE = 8'h10;
   localparam logic [7:0] OUT_STRIDE = 8'h10;
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] NVAL_OFS = 8'h04;
   localparam logic [7:0] DIAG_OFS = 8'h08;
   localparam logic [7:0] PULSE_OFS = 8'h0C;
   localparam logic [7:0] STATUS_ADDR = 8'h40;
   // Output config fields
   localparam int CF_MODE = 0;
   localparam int CF_CMP = 4;
   localparam int CF_CONSEC = 6;
   localparam int CF_INSIDE = 7;
   localparam int CF_INV = 8;
   localparam int CF_ZEN = 9;
   localparam int CF_ZSEL = 10;
   localparam int CF_GEN = 12;
   localparam int CF_GPOL = 13;
   localparam int CF_GSEL = 14;
   localparam int CFG_W = 15;
   // Diag config fields
   localparam int DG_TQEN = 5;
   localparam int DG_PQEN = 6;
   localparam int DG_TQTHR = 8;
   localparam int DG_PQTHR = 16;
   localparam int DIAG_W = 23;
   // Zone fields
   localparam int ZN_LAST = 8;
   localparam logic [CW-1:0] ZONE_FIRST_RST = 6'h01;
   localparam logic [CW-1:0] ZONE_LAST_RST = 6'h20;
   // Status fields
   localparam int ST_RAW = 2;
   localparam int ST_DIAG = 4;
   typedef enum logic [2:0] {
      LGE_OFF = 3'b000,
      LGE_OBJ_CNT = 3'b001,
      LGE_HOLE_CNT = 3'b010,
      LGE_DIM = 3'b011,
      LGE_OBJ_POS = 3'b100,
      LGE_HOLE_POS = 3'b101,
      LGE_DIAG = 3'b110
   } lge_mode_t;
   typedef enum logic [1:0] {
      LGE_GE = 2'b00,
      LGE_LE = 2'b01,
      LGE_EQ = 2'b10
   } lge_cmp_t;
endpackage

/* File: logic/lge_evaluator.sv */
// Light grid switching output evaluator with register port
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
module lge_evaluator #(
   parameter int MS_CYCLES = lge_pkg::MS_CYCLES
) (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [lge_pkg::BEAMS-1:0] BEAM_BLOCKED,
   input wire logic CONTAMINATION,
   input wire logic SHORT_CIRCUIT,
   input wire logic TEACH_ERROR,
   input wire logic HARDWARE_ERROR,
   input wire logic SYNC_ERROR,
   input wire logic [6:0] TEACH_QUALITY,
   input wire logic [6:0] PROCESS_QUALITY,
   input wire logic [1:0] CTRL_IN,
   output logic [lge_pkg::NOUT-1:0] SWITCHING_OUTPUT
);
   localparam int NB = lge_pkg::BEAMS;
   localparam int CW = lge_pkg::CW;
   localparam int NO = lge_pkg::NOUT;
   localparam logic [lge_pkg::SUBW-1:0] SUB_END =
      lge_pkg::SUBW'(MS_CYCLES - 1);
   localparam logic [lge_pkg::MSW-1:0] MS_ONE = lge_pkg::MSW'(1);

   logic [lge_pkg::CFG_W-1:0] cfg [NO];
   logic [CW-1:0] nval [NO];
   logic [lge_pkg::DIAG_W-1:0] dcfg [NO];
   logic [lge_pkg::MSW-1:0] minw [NO];
   logic [CW-1:0] zfirst [lge_pkg::NZONE];
   logic [CW-1:0] zlast [lge_pkg::NZONE];
   logic [NO-1:0] raw;
   logic [NO-1:0] eval_q;
   logic [NO-1:0] next_eval;
   logic [NO-1:0] want;
   logic [lge_pkg::MSW-1:0] ms_left [NO];
   logic [lge_pkg::SUBW-1:0] sub [NO];
   logic [4:0] flags;
   logic [NO-1:0] want_q;
   logic [NO-1:0] pend;
   logic [NO-1:0] busy;

   // Population count of a beam vector
   function automatic logic [CW-1:0] popcnt(input logic [NB-1:0] v);
      logic [CW-1:0] c;
      c = '0;
      for (int i = 0; i < NB; i++) begin
         c = c + CW'(v[i]);
      end
      return c;
   endfunction

   // Longest run of ones in v; enc asks that b bounds it on both sides
   function automatic logic [2*CW-1:0] longest(input logic [NB-1:0] v,
         input logic [NB-1:0] b, input logic enc);
      logic [CW-1:0] cur;
      logic [CW-1:0] best;
      logic [CW-1:0] st;
      logic [CW-1:0] best_st;
      logic lft;
      logic prv;
      cur = '0;
      best = '0;
      st = '0;
      best_st = '0;
      lft = 1'b0;
      prv = 1'b0;
      for (int i = 0; i < NB; i++) begin
         if (v[i]) begin
            if (cur == '0) begin
               st = CW'(i);
               lft = prv;
            end
            cur = cur + 1'b1;
         end else begin
            if (cur > best && (!enc || (lft && b[i]))) begin
               best = cur;
               best_st = st;
            end
            cur = '0;
         end
         prv = b[i];
      end
      if (cur > best && !enc) begin
         best = cur;
         best_st = st;
      end
      return {best, best_st};
   endfunction

   // One-based centre beam of a run given length and start index
   function automatic logic [CW-1:0] centre(input logic [2*CW-1:0] r);
      logic [CW-1:0] len;
      logic [CW-1:0] st;
      len = r[2*CW-1:CW];
      st = r[CW-1:0];
      if (len == '0) begin
         return '0;
      end
      return st + ((len - 1'b1) >> 1) + 1'b1;
   endfunction

   // Selected comparison of a measured value against n
   function automatic logic compare(input logic [CW-1:0] a,
         input logic [CW-1:0] n, input logic [1:0] c);
      case (c)
         lge_pkg::LGE_GE: return a >= n;
         lge_pkg::LGE_LE: return a <= n;
         lge_pkg::LGE_EQ: return a == n;
         default: return 1'b0;
      endcase
   endfunction

   // Byte address of a register of output k
   function automatic logic [7:0] oreg(input int k, input logic [7:0] ofs);
      return lge_pkg::OUT_BASE + lge_pkg::OUT_STRIDE * 8'(k) + ofs;
   endfunction

   // Span from first to last set beam
   function automatic logic [CW-1:0] span(input logic [NB-1:0] v);
      int f;
      int l;
      f = -1;
      l = -1;
      for (int i = 0; i < NB; i++) begin
         if (v[i]) begin
            if (f < 0) begin
               f = i;
            end
            l = i;
         end
      end
      if (f < 0) begin
         return '0;
      end
      return CW'(l - f + 1);
   endfunction

   assign flags = {SYNC_ERROR, HARDWARE_ERROR, TEACH_ERROR, SHORT_CIRCUIT,
      CONTAMINATION};

   // Per-output measuring and diagnostic evaluation
   always_comb begin
      logic [NB-1:0] zm;
      logic [NB-1:0] blk;
      logic [NB-1:0] made;
      logic [2*CW-1:0] rb;
      logic [2*CW-1:0] rm;
      logic [CW-1:0] meas;
      logic [1:0] zs;
      logic [1:0] cm;
      logic [4:0] den;
      logic diag;
      zm = '1;
      blk = '0;
      made = '0;
      rb = '0;
      rm = '0;
      meas = '0;
      zs = '0;
      cm = '0;
      den = '0;
      diag = 1'b0;
      for (int k = 0; k < NO; k++) begin
         zs = cfg[k][lge_pkg::CF_ZSEL+:2];
         cm = cfg[k][lge_pkg::CF_CMP+:2];
         zm = '1;
         if (cfg[k][lge_pkg::CF_ZEN]) begin
            for (int i = 0; i < NB; i++) begin
               zm[i] = (CW'(i + 1) >= zfirst[zs]) &&
                  (CW'(i + 1) <= zlast[zs]);
            end
         end
         blk = BEAM_BLOCKED & zm;
         made = ~BEAM_BLOCKED & zm;
         rb = longest(blk, blk, 1'b0);
         rm = longest(made, blk, 1'b0);
         case (cfg[k][lge_pkg::CF_MODE+:3])
            lge_pkg::LGE_OBJ_CNT: begin
               meas = cfg[k][lge_pkg::CF_CONSEC] ? rb[2*CW-1:CW]
                  : popcnt(blk);
               raw[k] = compare(meas, nval[k], cm);
            end
            lge_pkg::LGE_HOLE_CNT: begin
               meas = cfg[k][lge_pkg::CF_CONSEC] ? rm[2*CW-1:CW]
                  : popcnt(made);
               raw[k] = compare(meas, nval[k], cm);
            end
            lge_pkg::LGE_DIM: begin
               rm = longest(made, blk, 1'b1);
               meas = cfg[k][lge_pkg::CF_INSIDE] ? rm[2*CW-1:CW]
                  : span(blk);
               raw[k] = compare(meas, nval[k], cm);
            end
            lge_pkg::LGE_OBJ_POS: begin
               meas = centre(rb);
               raw[k] = (meas != '0) && compare(meas, nval[k], cm);
            end
            lge_pkg::LGE_HOLE_POS: begin
               meas = centre(rm);
               raw[k] = (meas != '0) && compare(meas, nval[k], cm);
            end
            lge_pkg::LGE_DIAG: begin
               den = dcfg[k][4:0];
               diag = |(den & flags);
               if (dcfg[k][lge_pkg::DG_TQEN] &&
                     TEACH_QUALITY < dcfg[k][lge_pkg::DG_TQTHR+:7]) begin
                  diag = 1'b1;
               end
               if (dcfg[k][lge_pkg::DG_PQEN] &&
                     PROCESS_QUALITY < dcfg[k][lge_pkg::DG_PQTHR+:7]) begin
                  diag = 1'b1;
               end
               raw[k] = diag;
            end
            default: begin
               raw[k] = 1'b0;
            end
         endcase
      end
   end

   // Input gate holds the evaluated state while the gate is inactive
   always_comb begin
      logic gin;
      gin = 1'b0;
      for (int k = 0; k < NO; k++) begin
         gin = CTRL_IN[cfg[k][lge_pkg::CF_GSEL]] ^ cfg[k][lge_pkg::CF_GPOL];
         next_eval[k] = (!cfg[k][lge_pkg::CF_GEN] || gin) ? raw[k]
            : eval_q[k];
         want[k] = eval_q[k] ^ cfg[k][lge_pkg::CF_INV];
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         eval_q <= '0;
      end else begin
         eval_q <= next_eval;
      end
   end

   // Hold in progress: the minimum width of the last edge has not elapsed
   always_comb begin
      for (int k = 0; k < NO; k++) begin
         busy[k] = (ms_left[k] > MS_ONE) ||
            (ms_left[k] == MS_ONE && sub[k] != SUB_END);
      end
   end

   // Minimum pulse width stretcher, one per output
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         SWITCHING_OUTPUT <= '0;
         want_q <= '0;
         pend <= '0;
         for (int k = 0; k < NO; k++) begin
            ms_left[k] <= '0;
            sub[k] <= '0;
         end
      end else begin
         want_q <= want;
         for (int k = 0; k < NO; k++) begin
            if (ms_left[k] != '0) begin
               if (sub[k] == SUB_END) begin
                  sub[k] <= '0;
                  ms_left[k] <= ms_left[k] - 1'b1;
               end else begin
                  sub[k] <= sub[k] + 1'b1;
               end
            end
            if (busy[k]) begin
               if (want[k] && !want_q[k]) begin
                  pend[k] <= 1'b1;
               end
            end else if (!SWITCHING_OUTPUT[k] && (want[k] || pend[k])) begin
               SWITCHING_OUTPUT[k] <= 1'b1;
               pend[k] <= 1'b0;
               ms_left[k] <= minw[k];
               sub[k] <= '0;
            end else if (SWITCHING_OUTPUT[k] && !want[k]) begin
               SWITCHING_OUTPUT[k] <= 1'b0;
               ms_left[k] <= minw[k];
               sub[k] <= '0;
            end else if (SWITCHING_OUTPUT[k]) begin
               pend[k] <= 1'b0;
            end
         end
      end
   end

   // Register writes
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         for (int k = 0; k < NO; k++) begin
            cfg[k] <= '0;
            nval[k] <= '0;
            dcfg[k] <= '0;
            minw[k] <= '0;
         end
         for (int z = 0; z < lge_pkg::NZONE; z++) begin
            zfirst[z] <= lge_pkg::ZONE_FIRST_RST;
            zlast[z] <= lge_pkg::ZONE_LAST_RST;
         end
      end else if (WR) begin
         for (int z = 0; z < lge_pkg::NZONE; z++) begin
            if (ADDR == lge_pkg::ZONE_BASE + 8'(4 * z)) begin
               zfirst[z] <= WDATA[CW-1:0];
               zlast[z] <= WDATA[lge_pkg::ZN_LAST+:CW];
            end
         end
         for (int k = 0; k < NO; k++) begin
            if (ADDR == oreg(k, lge_pkg::CFG_OFS)) begin
               cfg[k] <= WDATA[lge_pkg::CFG_W-1:0];
            end
            if (ADDR == oreg(k, lge_pkg::NVAL_OFS)) begin
               nval[k] <= WDATA[CW-1:0];
            end
            if (ADDR == oreg(k, lge_pkg::DIAG_OFS)) begin
               dcfg[k] <= WDATA[lge_pkg::DIAG_W-1:0];
            end
            if (ADDR == oreg(k, lge_pkg::PULSE_OFS)) begin
               minw[k] <= WDATA[lge_pkg::MSW-1:0];
            end
         end
      end
   end

   // Register reads, data valid only in the cycle after the strobe
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         RDATA <= '0;
      end else begin
         RDATA <= '0;
         if (RD) begin
            for (int z = 0; z < lge_pkg::NZONE; z++) begin
               if (ADDR == lge_pkg::ZONE_BASE + 8'(4 * z)) begin
                  RDATA <= {18'h0_0000, zlast[z], 2'b00, zfirst[z]};
               end
            end
            for (int k = 0; k < NO; k++) begin
               if (ADDR == oreg(k, lge_pkg::CFG_OFS)) begin
                  RDATA <= {17'h0_0000, cfg[k]};
               end
               if (ADDR == oreg(k, lge_pkg::NVAL_OFS)) begin
                  RDATA <= {26'h000_0000, nval[k]};
               end
               if (ADDR == oreg(k, lge_pkg::DIAG_OFS)) begin
                  RDATA <= {9'h000, dcfg[k]};
               end
               if (ADDR == oreg(k, lge_pkg::PULSE_OFS)) begin
                  RDATA <= {16'h0000, minw[k]};
               end
            end
            if (ADDR == lge_pkg::STATUS_ADDR) begin
               RDATA <= {23'h00_0000, flags, eval_q, SWITCHING_OUTPUT};
            end
         end
      end
   end
endmodule // lge_evaluator

/* File: dv/lge_evaluator_asserts.sv */
// Port checks for the light grid output evaluator
`timescale 1ns/100ps
module lge_evaluator_asserts #(
   parameter int MS_CYCLES = lge_pkg::MS_CYCLES
) (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic [lge_pkg::BEAMS-1:0] BEAM_BLOCKED,
   input wire logic CONTAMINATION,
   input wire logic SHORT_CIRCUIT,
   input wire logic TEACH_ERROR,
   input wire logic HARDWARE_ERROR,
   input wire logic SYNC_ERROR,
   input wire logic [6:0] TEACH_QUALITY,
   input wire logic [6:0] PROCESS_QUALITY,
   input wire logic [lge_pkg::NOUT-1:0] SWITCHING_OUTPUT
);
   logic [14:0] cfg0, cfg1;
   logic [5:0] n0, cnt;
   logic [15:0] pw0;
   logic [22:0] dg1;
   logic [23:0] since;
   logic od, cnt_on, diag_on, want0, want1;
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RESET);
   function automatic logic hit(input logic [5:0] v, input logic [5:0] n,
         input logic [1:0] c);
      return c == 2'h0 ? v >= n : c == 2'h1 ? v <= n : c == 2'h2 && v == n;
   endfunction
   // Shadow of the configuration seen on the register port
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         {cfg0, cfg1, n0, pw0, dg1} <= '0;
      end else if (WR) begin
         case (ADDR)
            8'h10: cfg0 <= WDATA[14:0];
            8'h14: n0 <= WDATA[5:0];
            8'h1C: pw0 <= WDATA[15:0];
            8'h20: cfg1 <= WDATA[14:0];
            8'h28: dg1 <= WDATA[22:0];
            default: ;
         endcase
      end
   end
   // Cycles since the last edge of the first output
   always_ff @(posedge MCLK) begin
      od <= RESET ? 1'b0 : SWITCHING_OUTPUT[0];
      if (RESET) since <= 24'hFF_FFFF;
      else if (SWITCHING_OUTPUT[0] != od) since <= 24'h00_0001;
      else if (since != 24'hFF_FFFF) since <= since + 24'h00_0001;
   end
   assign cnt = cfg0[1] ? 6'($countones(~BEAM_BLOCKED))
      : 6'($countones(BEAM_BLOCKED));
   assign cnt_on = (cfg0[2:0] == 3'h1 || cfg0[2:0] == 3'h2) && !cfg0[6]
      && cfg0[14:9] == 6'h00 && pw0 == 16'h0000;
   assign want0 = hit(cnt, n0, cfg0[5:4]) ^ cfg0[8];
   assign diag_on = cfg1[2:0] == 3'h6 && cfg1[14:9] == 6'h00;
   assign want1 = cfg1[8] ^ (|(dg1[4:0] & {SYNC_ERROR, HARDWARE_ERROR,
      TEACH_ERROR, SHORT_CIRCUIT, CONTAMINATION})
      || dg1[5] && TEACH_QUALITY < dg1[14:8]
      || dg1[6] && PROCESS_QUALITY < dg1[22:16]);
   sequence cnt_win;
      cnt_on ##1 $stable(cfg0) ##1 cnt_on;
   endsequence
   sequence diag_win;
      diag_on ##1 $stable(cfg1) ##1 diag_on;
   endsequence
   reset_clear_a: assert property (disable iff (1'b0) RESET |=>
      SWITCHING_OUTPUT == 2'h0 && RDATA == 32'h0000_0000)
      else $error("outputs not cleared by reset");
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
      else $error("read data outside read answer");
   unmapped_read_a: assert property (RD && ADDR == 8'hFC |=> RDATA == 0)
      else $error("unmapped read not zero");
   status_read_a: assert property (RD && ADDR == lge_pkg::STATUS_ADDR |=>
      RDATA[1:0] == $past(SWITCHING_OUTPUT) && RDATA[31:9] == 23'h00_0000)
      else $error("status read mismatch");
   cfg_read_a: assert property (RD && ADDR == 8'h10 |=>
      RDATA == {17'h0_0000, $past(cfg0)})
      else $error("config read back mismatch");
   count_out_a: assert property (cnt_win |->
      SWITCHING_OUTPUT[0] == $past(want0, 2))
      else $error("count output mismatch");
   diag_out_a: assert property (diag_win |->
      SWITCHING_OUTPUT[1] == $past(want1, 2))
      else $error("diagnostic output mismatch");
   stretch_hold_a: assert property (pw0 != 16'h0000 &&
      SWITCHING_OUTPUT[0] != od |-> since >= pw0 * MS_CYCLES)
      else $error("output edge inside minimum width");
endmodule // lge_evaluator_asserts

bind lge_evaluator lge_evaluator_asserts #(.MS_CYCLES(MS_CYCLES)) chk (
   .MCLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .BEAM_BLOCKED,
   .CONTAMINATION, .SHORT_CIRCUIT, .TEACH_ERROR, .HARDWARE_ERROR,
   .SYNC_ERROR, .TEACH_QUALITY, .PROCESS_QUALITY, .SWITCHING_OUTPUT);

/* File: dv/lge_ctrl_model.sv */
// Slow controller model measuring the first switching output
`timescale 1ns/100ps
module lge_ctrl_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] sw,
   output logic [23:0] hi_len,
   output logic [23:0] lo_len,
   output logic [7:0] rises
);
   logic [23:0] run;
   logic last;
   // Length of the last high pulse and low gap, count of rises
   always_ff @(posedge clk) begin
      if (rst) begin
         {hi_len, lo_len, rises, run, last} <= '0;
      end else if (sw[0] != last) begin
         if (last) hi_len <= run;
         else lo_len <= run;
         if (!last) rises <= rises + 8'h01;
         run <= 24'h00_0001;
         last <= sw[0];
      end else begin
         run <= run + 24'h00_0001;
      end
   end
endmodule // lge_ctrl_model

/* File: dv/lge_evaluator_test.sv */
// Directed testbench for the light grid output evaluator
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module lge_evaluator_test;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] beam = 32'h0000_0000;
   logic [31:0] rdata;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [4:0] flg = 5'h00;
   logic [6:0] tq = 7'h64;
   logic [6:0] pq = 7'h64;
   logic [1:0] ctl = 2'h1;
   logic [1:0] sw;
   logic [23:0] hi_len, lo_len;
   logic [7:0] rises, r0;
   int err_total = 0;
   int checked = 0;
   lge_evaluator #(.MS_CYCLES(10)) uut (.MCLK(mclk), .RESET(reset),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .BEAM_BLOCKED(beam), .CONTAMINATION(flg[0]), .SHORT_CIRCUIT(flg[1]),
      .TEACH_ERROR(flg[2]), .HARDWARE_ERROR(flg[3]), .SYNC_ERROR(flg[4]),
      .TEACH_QUALITY(tq), .PROCESS_QUALITY(pq), .CTRL_IN(ctl),
      .SWITCHING_OUTPUT(sw));
   lge_ctrl_model plc (.clk(mclk), .rst(reset), .sw(sw),
      .hi_len(hi_len), .lo_len(lo_len), .rises(rises));
   initial begin
      forever #50 mclk = ~mclk;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask
   task automatic settle(input logic [31:0] b);
      @(posedge mclk);
      beam <= b;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic tc(input logic [31:0] c, input logic [5:0] n,
         input logic [31:0] b, input logic e);
      wr_reg(8'h10, c);
      wr_reg(8'h14, {26'h0, n});
      settle(b);
      `CHK(sw[0], e)
   endtask
   task automatic dc(input logic [31:0] d, input logic [4:0] f,
         input logic [6:0] t, input logic [6:0] p, input logic e);
      wr_reg(8'h28, d);
      @(posedge mclk);
      flg <= f;
      tq <= t;
      pq <= p;
      repeat (3) @(posedge mclk);
      #1;
      `CHK(sw[1], e)
   endtask
   task automatic pulse(input int len);
      @(posedge mclk);
      beam <= 32'h0000_0001;
      repeat (len) @(posedge mclk);
      beam <= 32'h0000_0000;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      rd_chk(8'h00, 32'h0000_2001);
      rd_chk(8'h10, 32'h0000_0000);
      wr_reg(8'hFC, 32'hFFFF_FFFF);
      rd_chk(8'hFC, 32'h0000_0000);
      wr_reg(8'h14, 32'hFFFF_FFFF);
      rd_chk(8'h14, 32'h0000_003F);
      rd_chk(8'h40, 32'h0000_0000);
      $display("register test done");
      tc(32'h0000_0001, 6'h03, 32'h0000_0015, 1'b1);
      tc(32'h0000_0041, 6'h03, 32'h0000_0015, 1'b0);
      tc(32'h0000_0011, 6'h02, 32'h0000_0015, 1'b0);
      tc(32'h0000_0021, 6'h03, 32'h0000_0007, 1'b1);
      tc(32'h0000_0002, 6'h01, 32'hFFFF_FFFE, 1'b1);
      tc(32'h0000_0002, 6'h01, 32'hFFFF_FFFF, 1'b0);
      tc(32'h0000_0062, 6'h02, 32'hFFFF_FF99, 1'b1);
      tc(32'h0000_0022, 6'h02, 32'hFFFF_FF99, 1'b0);
      tc(32'h0000_0012, 6'h04, 32'hFFFF_FF99, 1'b1);
      tc(32'h0000_0023, 6'h04, 32'h0000_0F00, 1'b1);
      tc(32'h0000_00A3, 6'h04, 32'h0000_0F0F, 1'b1);
      tc(32'h0000_0083, 6'h05, 32'h0000_0F0F, 1'b0);
      tc(32'h0000_0024, 6'h0D, 32'h0000_7C03, 1'b1);
      tc(32'h0000_0014, 6'h0C, 32'h0000_7C03, 1'b0);
      tc(32'h0000_0025, 6'h16, 32'hFF8F_FFFB, 1'b1);
      tc(32'h0000_0005, 6'h17, 32'hFF8F_FFFB, 1'b0);
      tc(32'h0000_0101, 6'h03, 32'h0000_0015, 1'b0);
      wr_reg(8'h04, 32'h0000_0805);
      tc(32'h0000_0601, 6'h02, 32'h0000_000F, 1'b0);
      tc(32'h0000_0601, 6'h02, 32'h0000_0030, 1'b1);
      tc(32'h0000_1001, 6'h01, 32'h0000_0000, 1'b0);
      @(posedge mclk);
      ctl <= 2'h0;
      settle(32'h0000_0001);
      `CHK(sw[0], 1'b0)
      @(posedge mclk);
      ctl <= 2'h1;
      settle(32'h0000_0001);
      `CHK(sw[0], 1'b1)
      rd_chk(8'h40, 32'h0000_0005);
      $display("count test done");
      wr_reg(8'h20, 32'h0000_0006);
      for (int i = 0; i < 5; i++) begin
         dc(32'h1 << i, 5'h1F ^ (5'h01 << i), 7'h64, 7'h64, 1'b0);
         dc(32'h1 << i, 5'h01 << i, 7'h64, 7'h64, 1'b1);
      end
      dc(32'h0000_3220, 5'h00, 7'h31, 7'h64, 1'b1);
      dc(32'h0000_3220, 5'h00, 7'h32, 7'h00, 1'b0);
      dc(32'h0032_0040, 5'h00, 7'h00, 7'h31, 1'b1);
      dc(32'h0032_0040, 5'h00, 7'h64, 7'h32, 1'b0);
      wr_reg(8'h20, 32'h0000_0106);
      dc(32'h0000_0001, 5'h00, 7'h64, 7'h64, 1'b1);
      $display("diagnostic test done");
      tc(32'h0000_0001, 6'h01, 32'h0000_0000, 1'b0);
      wr_reg(8'h1C, 32'h0000_0002);
      repeat (25) @(posedge mclk);
      r0 = rises;
      pulse(3);
      repeat (2) @(posedge mclk);
      pulse(3);
      repeat (80) @(posedge mclk);
      #1;
      `CHK(hi_len, 24'h00_0014)
      `CHK(lo_len >= 24'h00_0014, 1'b1)
      `CHK(rises - r0, 8'h02)
      pulse(40);
      repeat (60) @(posedge mclk);
      #1;
      `CHK(hi_len, 24'h00_0028)
      $display("stretch test done");
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      complete_run;
   end
endmodule // lge_evaluator_test
